/* File: rtl/fes_pkg.sv */
package fes_pkg;

	localparam int unsigned  CLK_PERIOD_NS   = 100;
	localparam logic [7:0]   CMD_READ_ARRAY  = 8'hff;
	localparam logic [7:0]   CMD_READ_STATUS = 8'h70;
	localparam logic [7:0]   CMD_CLEAR_STAT  = 8'h50;
	localparam logic [7:0]   CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0]   CMD_CONFIRM     = 8'hd0;
	localparam logic [7:0]   CMD_SUSPEND     = 8'hb0;
	localparam logic [7:0]   CMD_WRITE_SETUP = 8'h40;

	localparam int unsigned  BIT_READY       = 7;
	localparam int unsigned  BIT_PAUSED      = 6;
	localparam int unsigned  BIT_ERASE_FAIL  = 5;
	localparam int unsigned  BIT_PROG_FAIL   = 4;
	localparam int unsigned  BIT_SUPPLY_MISS = 3;

	localparam logic [11:0]  REG_CTRL        = 12'h000;
	localparam logic [11:0]  REG_ADDR        = 12'h004;
	localparam logic [11:0]  REG_DATA        = 12'h008;
	localparam logic [11:0]  REG_STAT        = 12'h00c;
	localparam logic [11:0]  REG_RDATA       = 12'h010;

	localparam int unsigned  OP_BIT_GO       = 0;
	localparam logic [2:0]   OP_ARRAY_READ   = 3'd0;
	localparam logic [2:0]   OP_STATUS_READ  = 3'd1;
	localparam logic [2:0]   OP_CLEAR        = 3'd2;
	localparam logic [2:0]   OP_ERASE        = 3'd3;
	localparam logic [2:0]   OP_PROGRAM      = 3'd4;
	localparam logic [2:0]   OP_SUSPEND      = 3'd5;
	localparam logic [2:0]   OP_RESUME       = 3'd6;
	localparam logic [2:0]   OP_RESET        = 3'd7;

	localparam int unsigned  T_STROBE_NS     = 200;
	localparam int unsigned  T_STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned  T_RESET_NS      = 1000;
	localparam int unsigned  T_RESET_CYC     = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0]
	{
		FES_IDLE  = 3'b000,
		FES_SETUP = 3'b001,
		FES_WLOW  = 3'b011,
		FES_WHIGH = 3'b010,
		FES_RLOW  = 3'b110,
		FES_DONE  = 3'b111,
		FES_RST   = 3'b101
	} fes_state_t;

	function automatic logic [2:0] fes_decode_err(input logic [7:0] s);
		fes_decode_err = {s[BIT_ERASE_FAIL], s[BIT_PROG_FAIL], s[BIT_SUPPLY_MISS]};
	endfunction : fes_decode_err

endpackage : fes_pkg

/* File: rtl/fes_sync.sv */
`timescale 1ns/1ps
module fes_sync #(
	parameter int W = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic [W-1:0]  d,
	output logic [W-1:0]       q
);
	logic [W-1:0] s1_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= '0;
			q    <= '0;
		end
		else
		begin
			s1_q <= d;
			q    <= s1_q;
		end
	end
endmodule : fes_sync

/* File: rtl/fes_ctrl.sv */
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - During an erase only suspend, status read, resume or reset is sent; other operations are refused.
// - While suspended only array read, resume, status read or reset are issued.
// - Error flags are taken from every status read, whether or not the ready flag reads one.
// - Reset/power-down is held low out of reset, chip select high.
// - Controller issues array read before array data after an operation.
// - Status check is optional but supply-missing still blocks.
// - Erase is setup 20h then confirm d0h at the block address.
module fes_ctrl #(
	parameter int AW = 20
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	output logic [AW-1:0]      flash_addr,
	output logic [15:0]        flash_dq_out,
	output logic               flash_dq_oe,
	input  wire logic [15:0]   flash_dq_in,
	output logic               flash_ce_n,
	output logic               flash_we_n,
	output logic               flash_oe_n,
	output logic               reset_powerdown_n
);
	import fes_pkg::*;

	fes_state_t   st_q;
	logic [2:0]   op_q;
	logic [AW-1:0] addr_q;
	logic [15:0]  data_q;
	logic [15:0]  rdata_q;
	logic [7:0]   stat_q;
	logic         second_q;
	logic         refused_q;
	logic         erasing_q;
	logic         pd_q;
	logic [3:0]   cnt_q;
	logic [15:0]  dq_s;
	logic         wr_acc;
	logic         go;
	logic         busy;
	logic [2:0]   new_op;
	logic         allowed;
	logic [7:0]   cmd1;

	fes_sync #(.W(16)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (flash_dq_in),
		.q       (dq_s)
	);

	assign wr_acc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign busy = (st_q != FES_IDLE);
	assign new_op = pwdata[3:1];
	assign go = wr_acc && (paddr == REG_CTRL) && pwdata[OP_BIT_GO] && !busy;

	always_comb
	begin
		allowed = 1'b1;
		if (erasing_q && !stat_q[BIT_PAUSED] && new_op != OP_SUSPEND
			&& new_op != OP_STATUS_READ && new_op != OP_RESUME)
			allowed = 1'b0;
		// Suspended is taken as paused and ready both read back as one.
		if (erasing_q && stat_q[BIT_PAUSED] && stat_q[BIT_READY]
			&& !(new_op inside {OP_ARRAY_READ, OP_RESUME, OP_STATUS_READ}))
			allowed = 1'b0;
		if ((new_op == OP_ERASE || new_op == OP_PROGRAM) && stat_q[BIT_SUPPLY_MISS])
			allowed = 1'b0;
		if (new_op == OP_RESET)
			allowed = 1'b1;
	end

	always_comb
	begin
		unique case (op_q)
			OP_ARRAY_READ:  cmd1 = CMD_READ_ARRAY;
			OP_STATUS_READ: cmd1 = CMD_READ_STATUS;
			OP_CLEAR:       cmd1 = CMD_CLEAR_STAT;
			OP_ERASE:       cmd1 = CMD_ERASE_SETUP;
			OP_PROGRAM:     cmd1 = CMD_WRITE_SETUP;
			OP_SUSPEND:     cmd1 = CMD_SUSPEND;
			OP_RESUME:      cmd1 = CMD_CONFIRM;
			OP_RESET:       cmd1 = CMD_READ_ARRAY;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q <= '0;
			data_q <= 16'h0000;
		end
		else if (wr_acc && paddr == REG_ADDR && !busy)
			addr_q <= pwdata[AW-1:0];
		else if (wr_acc && paddr == REG_DATA && !busy)
			data_q <= pwdata[15:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q      <= FES_RST;
			op_q      <= OP_RESET;
			cnt_q     <= 4'h0;
			second_q  <= 1'b0;
			refused_q <= 1'b0;
			pd_q      <= 1'b0;
			rdata_q   <= 16'h0000;
		end
		else
		begin
			unique case (st_q)
				FES_IDLE:
				begin
					if (go && !allowed)
						refused_q <= 1'b1;
					else if (go)
					begin
						refused_q <= 1'b0;
						op_q      <= new_op;
						second_q  <= 1'b0;
						cnt_q     <= 4'h0;
						if (new_op == OP_RESET)
						begin
							pd_q <= 1'b0;
							st_q <= FES_RST;
						end
						else
							st_q <= FES_SETUP;
					end
					else if (wr_acc && paddr == REG_CTRL)
						pd_q <= pwdata[4];
				end
				FES_SETUP:
				begin
					cnt_q <= 4'h0;
					st_q  <= FES_WLOW;
				end
				FES_WLOW:
				begin
					if (cnt_q == 4'(T_STROBE_CYC - 1))
					begin
						cnt_q <= 4'h0;
						st_q  <= FES_WHIGH;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				end
				FES_WHIGH:
				begin
					cnt_q <= 4'h0;
					if (!second_q && (op_q == OP_ERASE || op_q == OP_PROGRAM))
					begin
						second_q <= 1'b1;
						st_q     <= FES_SETUP;
					end
					else if (op_q == OP_CLEAR || op_q == OP_RESUME)
						st_q <= FES_DONE;
					else
						st_q <= FES_RLOW;
				end
				FES_RLOW:
				begin
					if (cnt_q == 4'(T_STROBE_CYC + 1))
					begin
						rdata_q <= dq_s;
						st_q    <= FES_DONE;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				end
				FES_DONE:
					st_q <= FES_IDLE;
				FES_RST:
				begin
					if (cnt_q == 4'(T_RESET_CYC - 1))
					begin
						cnt_q <= 4'h0;
						st_q  <= FES_IDLE;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				end
				default:
					st_q <= FES_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_q    <= 8'h80;
			erasing_q <= 1'b0;
		end
		else if (st_q == FES_RST)
		begin
			stat_q    <= 8'h80;
			erasing_q <= 1'b0;
		end
		else if (st_q == FES_DONE)
		begin
			if (op_q == OP_CLEAR)
				stat_q <= {stat_q[7:6], 3'b000, stat_q[2:0]};
			else if (op_q == OP_RESUME)
				stat_q[BIT_PAUSED] <= 1'b0;
			else if (op_q != OP_ARRAY_READ)
			begin
				stat_q <= {rdata_q[7:3], 3'b000} | {2'b00, stat_q[5:3], 3'b000};
				if (rdata_q[BIT_READY] && !rdata_q[BIT_PAUSED] && op_q != OP_SUSPEND)
					erasing_q <= 1'b0;
			end
			if (op_q == OP_ERASE)
				erasing_q <= 1'b1;
			if (op_q == OP_RESUME)
				erasing_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				REG_CTRL:  prdata <= {27'h0, pd_q, op_q, busy};
				REG_ADDR:  prdata <= {{(32 - AW){1'b0}}, addr_q};
				REG_DATA:  prdata <= {16'h0000, data_q};
				REG_STAT:  prdata <= {19'h0, erasing_q, refused_q, fes_decode_err(stat_q),
					stat_q[7:3], 3'b000};
				REG_RDATA: prdata <= {16'h0000, rdata_q};
				default:   prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_ce_n        <= 1'b1;
			flash_we_n        <= 1'b1;
			flash_oe_n        <= 1'b1;
			flash_dq_oe       <= 1'b0;
			flash_dq_out      <= 16'h0000;
			flash_addr        <= '0;
			reset_powerdown_n <= 1'b0;
		end
		else
		begin
			reset_powerdown_n <= (st_q != FES_RST) && !pd_q;
			flash_ce_n  <= !(st_q == FES_SETUP || st_q == FES_WLOW || st_q == FES_RLOW);
			flash_we_n  <= !(st_q == FES_WLOW);
			flash_oe_n  <= !(st_q == FES_RLOW);
			flash_dq_oe <= (st_q == FES_SETUP || st_q == FES_WLOW);
			flash_addr  <= addr_q;
			flash_dq_out <= second_q ? (op_q == OP_ERASE ? {8'h00, CMD_CONFIRM} : data_q)
				: {8'h00, cmd1};
		end
	end

	property p_rst_low;
		@(posedge pclk) disable iff (!presetn) (st_q == FES_RST) |=> !reset_powerdown_n;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("reset pin not low");

	property p_we_oe_excl;
		@(posedge pclk) disable iff (!presetn) !(!flash_we_n && !flash_oe_n);
	endproperty
	a_we_oe_excl: assert property (p_we_oe_excl) else $error("we and oe both low");

	property p_two_cycles;
		@(posedge pclk) disable iff (!presetn)
			(st_q == FES_WHIGH && !second_q && op_q == OP_ERASE) |=> (st_q == FES_SETUP);
	endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("second cycle missing");

	property p_supply_block;
		@(posedge pclk) disable iff (!presetn)
			(go && stat_q[BIT_SUPPLY_MISS] && new_op == OP_ERASE) |=> refused_q && !busy;
	endproperty
	a_supply_block: assert property (p_supply_block) else $error("op not blocked");

	property p_flags_kept;
		@(posedge pclk) disable iff (!presetn)
			(stat_q[BIT_SUPPLY_MISS] && !(st_q == FES_DONE && op_q == OP_CLEAR)
				&& st_q != FES_RST) |=> stat_q[BIT_SUPPLY_MISS];
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flag lost");

	property p_erase_refuse;
		@(posedge pclk) disable iff (!presetn)
			(go && erasing_q && !stat_q[BIT_PAUSED] && new_op == OP_PROGRAM) |=> refused_q;
	endproperty
	a_erase_refuse: assert property (p_erase_refuse) else $error("cmd during erase");

	property p_confirm_code;
		@(posedge pclk) disable iff (!presetn)
			(!flash_we_n && second_q && op_q == OP_ERASE) |-> flash_dq_out[7:0] == CMD_CONFIRM;
	endproperty
	a_confirm_code: assert property (p_confirm_code) else $error("bad confirm");

	property p_strobe_len;
		@(posedge pclk) disable iff (!presetn)
			$fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("bad strobe width");

	c_erase:   cover property (@(posedge pclk) disable iff (!presetn) go && new_op == OP_ERASE);
	c_suspend: cover property (@(posedge pclk) disable iff (!presetn) go && new_op == OP_SUSPEND);
	c_refuse:  cover property (@(posedge pclk) disable iff (!presetn) $rose(refused_q));
endmodule : fes_ctrl

/* File: sim/fes_flash_model.sv */
`timescale 1ns/1ps
module fes_flash_model #(
	parameter int ERASE_CYC = 150
) (
	input  wire logic         pclk,
	input  wire logic [19:0]  flash_addr,
	input  wire logic [15:0]  flash_dq_out,
	input  wire logic         flash_ce_n,
	input  wire logic         flash_we_n,
	input  wire logic         flash_oe_n,
	input  wire logic         reset_powerdown_n,
	input  wire logic         supply_bad,
	input  wire logic         erase_bad,
	output logic [15:0]       flash_dq_in
);
	import fes_pkg::*;
	// The model runs on pclk: a command is taken on the first pclk edge that sees we low with ce low, and the erase counts pclk cycles.
	logic [7:0]   sr_q;
	logic         stat_q, er_set_q, pr_set_q, busy_q, pause_q, we_prev_q;
	logic [15:0]  last_q = 16'h0;
	int           cnt_q;
	wire logic [7:0] cmd = flash_dq_out[7:0];
	wire logic       wr  = !flash_we_n && we_prev_q && !flash_ce_n;

	always @(posedge pclk or negedge reset_powerdown_n)
	begin
		if (!reset_powerdown_n)
		begin
			sr_q <= 8'h80;
			{stat_q, er_set_q, pr_set_q, busy_q, pause_q} <= '0;
			we_prev_q <= 1'b1;
			cnt_q <= 0;
		end
		else
		begin
			we_prev_q <= flash_we_n;
			if (busy_q && !pause_q && cnt_q == 0)
			begin
				busy_q <= 1'b0;
				sr_q[7] <= 1'b1;
				sr_q[5] <= erase_bad;
			end
			else if (busy_q && !pause_q)
				cnt_q <= cnt_q - 1;
			if (wr && busy_q && !pause_q)
			begin
				if (cmd == CMD_SUSPEND)
				begin
					pause_q <= 1'b1;
					sr_q[7:6] <= 2'b11;
				end
			end
			else if (wr && pause_q)
			begin
				if (cmd == CMD_CONFIRM)
				begin
					pause_q <= 1'b0;
					sr_q[7:6] <= 2'b00;
				end
				else if (cmd == CMD_READ_ARRAY)
					stat_q <= 1'b0;
				else if (cmd == CMD_READ_STATUS)
					stat_q <= 1'b1;
			end
			else if (wr && (er_set_q || pr_set_q))
			begin
				{er_set_q, pr_set_q} <= 2'b00;
				stat_q <= 1'b1;
				if (sr_q[3] || supply_bad)
					sr_q[3] <= 1'b1;
				else if (er_set_q && cmd != CMD_CONFIRM)
					sr_q[5:4] <= 2'b11;
				else if (er_set_q)
				begin
					busy_q <= 1'b1;
					cnt_q <= ERASE_CYC;
					sr_q[7] <= 1'b0;
				end
			end
			else if (wr)
			begin
				case (cmd)
					CMD_READ_ARRAY:  stat_q <= 1'b0;
					CMD_READ_STATUS: stat_q <= 1'b1;
					CMD_CLEAR_STAT:  sr_q[5:3] <= 3'b000;
					CMD_ERASE_SETUP: er_set_q <= 1'b1;
					CMD_WRITE_SETUP: pr_set_q <= 1'b1;
					default: ;
				endcase
			end
		end
	end

	always @(posedge pclk)
		last_q <= flash_dq_in;

	// A released bus shows the inverse of its last value, so a stale sample cannot pass.
	always_comb
		if (!flash_ce_n && !flash_oe_n && reset_powerdown_n)
			flash_dq_in = (stat_q || (busy_q && !pause_q)) ? {8'h00, sr_q}
				: flash_addr[15:0] ^ 16'h3c5a;
		else
			flash_dq_in = ~last_q;
endmodule : fes_flash_model

/* File: sim/fes_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module fes_ctrl_tb_top;
	import fes_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, r;
	logic [19:0]  flash_addr;
	logic [15:0]  dq_out, dq_in;
	logic         dq_oe, ce_n, we_n, oe_n, reset_powerdown_n, supply_bad, erase_bad;
	int           n_fail, compares, cyc, n_we, n0;

	fes_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.reset_powerdown_n(reset_powerdown_n));
	fes_flash_model u_flash (.pclk(pclk), .flash_addr(flash_addr), .flash_dq_out(dq_out),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
		.reset_powerdown_n(reset_powerdown_n), .supply_bad(supply_bad),
		.erase_bad(erase_bad), .flash_dq_in(dq_in));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(negedge we_n)
		n_we++;

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_idle;
		logic [31:0] q;
		int n;
		n = 0;
		do
		begin
			apb(REG_CTRL, 1'b0, 32'h0, q);
			n++;
		end
		while (q[0] !== 1'b0 && n < 100);
		`CHK("idle", 1'b0, q[0])
	endtask : wait_idle

	task automatic op(input logic [2:0] o);
		logic [31:0] q;
		apb(REG_CTRL, 1'b1, {28'h0, o, 1'b1}, q);
		wait_idle();
	endtask : op

	task automatic stat(output logic [31:0] q);
		op(OP_STATUS_READ);
		apb(REG_STAT, 1'b0, 32'h0, q);
	endtask : stat

	initial
	begin
		{presetn, psel, penable, pwrite, supply_bad, erase_bad} = '0;
		paddr = 12'h0;
		pwdata = 32'h0;
		{n_fail, compares, cyc, n_we} = '0;
		repeat (2) @(posedge pclk);
		`CHK("powerdown in reset", 1'b0, reset_powerdown_n)
		`CHK("chip select in reset", 1'b1, ce_n)
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(REG_CTRL, 1'b0, 32'h0, r);
		`CHK("busy after reset", 1'b1, r[0])
		wait_idle();
		`CHK("powerdown released", 1'b1, reset_powerdown_n)
		stat(r);
		`CHK("status after reset", 8'h80, r[7:0])
		apb(REG_ADDR, 1'b1, 32'h0001_2345, r);
		op(OP_ARRAY_READ);
		apb(REG_RDATA, 1'b0, 32'h0, r);
		`CHK("array data", 16'h2345 ^ 16'h3c5a, r[15:0])
		`CHK("standby", 1'b1, ce_n)
		$display("test reset and read done");
		supply_bad <= 1'b1;
		apb(REG_DATA, 1'b1, 32'h0000_1234, r);
		op(OP_PROGRAM);
		stat(r);
		`CHK("supply flag", 5'b10001, r[7:3])
		`CHK("supply code", 3'b001, r[10:8])
		supply_bad <= 1'b0;
		op(OP_ERASE);
		apb(REG_STAT, 1'b0, 32'h0, r);
		`CHK("refused on supply", 1'b1, r[11])
		op(OP_CLEAR);
		stat(r);
		`CHK("flags cleared", 8'h80, r[7:0])
		$display("test supply flag done");
		erase_bad <= 1'b1;
		apb(REG_ADDR, 1'b1, 32'h0002_0000, r);
		n0 = n_we;
		op(OP_ERASE);
		`CHK("erase strobes", 2, n_we - n0)
		`CHK("block address", 20'h20000, flash_addr)
		stat(r);
		`CHK("busy in erase", 1'b0, r[7])
		`CHK("erasing", 1'b1, r[12])
		op(OP_PROGRAM);
		apb(REG_STAT, 1'b0, 32'h0, r);
		`CHK("refused in erase", 1'b1, r[11])
		op(OP_SUSPEND);
		stat(r);
		`CHK("paused and ready", 2'b11, r[7:6])
		op(OP_ERASE);
		apb(REG_STAT, 1'b0, 32'h0, r);
		`CHK("refused in suspend", 1'b1, r[11])
		apb(REG_ADDR, 1'b1, 32'h0004_0abc, r);
		op(OP_ARRAY_READ);
		apb(REG_RDATA, 1'b0, 32'h0, r);
		`CHK("array in suspend", 16'h0abc ^ 16'h3c5a, r[15:0])
		op(OP_RESUME);
		stat(r);
		`CHK("resumed", 2'b00, r[7:6])
		n0 = 0;
		do
		begin
			stat(r);
			n0++;
		end
		while (r[7] !== 1'b1 && n0 < 40);
		`CHK("erase fail code", 3'b100, r[10:8])
		`CHK("erase over", 1'b0, r[12])
		stat(r);
		`CHK("fail kept", 1'b1, r[5])
		$display("test erase suspend done");
		apb(REG_CTRL, 1'b1, 32'h0000_0010, r);
		repeat (2) @(posedge pclk);
		`CHK("deep power-down", 1'b0, reset_powerdown_n)
		apb(REG_CTRL, 1'b1, 32'h0, r);
		wait_idle();
		op(OP_RESET);
		stat(r);
		`CHK("status after pulse", 8'h80, r[7:0])
		$display("test power-down done");
		wrap_up();
	end
endmodule : fes_ctrl_tb_top
